// ---- bench/eps_dev_model.sv ----
// behavioural word eprom facing the sequencer
`timescale 1ns/1ps
module eps_dev_model #(
    parameter [15:0] MFR_ID = 16'h5a01, // arbitrary value
    parameter [15:0] DEV_ID = 16'h5a02  // arbitrary value
) (
    // clock for the hold register only
    input  wire        mclk,
    // eprom pins
    input  wire [18:0] ep_addr,
    input  wire [15:0] ep_dout,
    input  wire        ep_cs_n,
    input  wire        ep_oe_n,
    input  wire        ep_id_hv,
    input  wire        ep_vcc_prog,
    input  wire        ep_vpp_on,
    input  wire        ep_width_word,
    output wire [15:0] ep_din
);
    reg  [15:0] mem  [0:7];
    reg  [7:0]  need [0:7];
    reg  [7:0]  cnt  [0:7];
    reg  [15:0] last = 16'h0000;
    wire [15:0] word;
    wire        drive;
    // a cell takes its data only once its pulse count reaches need
    always @(posedge ep_cs_n) begin
        if (ep_vpp_on && ep_vcc_prog && ep_oe_n) begin
            cnt[ep_addr[2:0]] = cnt[ep_addr[2:0]] + 8'h01;
            if (cnt[ep_addr[2:0]] >= need[ep_addr[2:0]])
                mem[ep_addr[2:0]] = ep_dout;
        end
    end
    // id words replace the array while the high-voltage line is up
    assign word  = ep_id_hv ? (ep_addr[0] ? DEV_ID : MFR_ID) : mem[ep_addr[2:0]];
    assign drive = !ep_oe_n && (ep_vpp_on || !ep_cs_n);
    // byte mode reuses the top data pin as lowest address bit
    assign ep_din = !drive ? ~last : ep_width_word ? word : {8'h00, ep_dout[15] ? word[15:8] : word[7:0]};
    // a released bus shows the inverse of the last word, never a stale copy
    always @(posedge mclk) begin
        if (drive)
            last <= ep_din;
    end
endmodule

// ---- bench/eps_seq_props.sv ----
// assertions on the pins of the eprom programming sequencer
`timescale 1ns/1ps
module eps_seq_props #(
    parameter AW     = 19,
    parameter PW_CYC = 6250
) (
    // clock and reset
    input wire          mclk,
    input wire          rst,
    // command port
    input wire          done,
    input wire          pass,
    input wire          fail,
    // eprom pins, then start and busy of the command port
    input wire [AW-1:0] ep_addr,
    input wire [15:0]   ep_dout,
    input wire          ep_doe_n,
    input wire          ep_cs_n,
    input wire          ep_oe_n,
    input wire          ep_id_hv,
    input wire          ep_vcc_prog,
    input wire          ep_vpp_on,
    input wire          ep_width_word,
    input wire          start,
    input wire          busy
);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    reg [15:0] lowcnt;
    reg        first;
    wire       pgm = !ep_cs_n && ep_oe_n;
    // counts edges of one programming pulse; a counter is cheaper than long repetition
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            lowcnt <= 16'h0000;
            first  <= 1'b0;
        end else begin
            lowcnt <= pgm ? lowcnt + 16'h0001 : 16'h0000;
            first  <= (start && !busy) ? 1'b1 : ((pgm && lowcnt == 16'h0000) ? 1'b0 : first);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    AST_PULSE_LEN: assert property (lowcnt != 16'h0000 && !pgm |-> lowcnt == PW_CYC)
        else $error("program pulse length off");
    AST_FIRST_ADDR: assert property (first && pgm && lowcnt == 16'h0000 |-> ep_addr == 0)
        else $error("first pulse not at address zero");
    AST_PULSE_SUPPLY: assert property (pgm |-> ep_vpp_on && ep_vcc_prog && !ep_doe_n)
        else $error("pulse without supplies or data");
    AST_VPP_ON_ORDER: assert property ($rose(ep_vpp_on) |-> $past(ep_vcc_prog))
        else $error("program supply before core supply");
    AST_VCC_OFF_ORDER: assert property ($fell(ep_vcc_prog) |-> !ep_vpp_on && !$past(ep_vpp_on))
        else $error("core supply dropped first");
    AST_PULSE_HOLD: assert property (pgm && lowcnt != 16'h0000 |-> $stable(ep_addr) && $stable(ep_dout))
        else $error("address or data moved in pulse");
    AST_ID_ADDR: assert property (ep_id_hv && !ep_oe_n |-> ep_addr[AW-1:1] == 0 && !ep_vpp_on)
        else $error("id read with stray address bits");
    AST_WORD_MODE: assert property (ep_width_word)
        else $error("width pin left low");
    AST_DONE_ONCE: assert property (done |-> (pass != fail) ##1 !done)
        else $error("done not a single pulse with one verdict");
    COV_PULSE: cover property (lowcnt == PW_CYC);
    COV_ID: cover property (ep_id_hv && !ep_oe_n);
    COV_FAIL: cover property (done && fail);
endmodule
bind eps_seq eps_seq_props #(.AW(AW), .PW_CYC(PW_CYC)) i_eps_seq_props (.mclk(mclk), .rst(rst), .done(done),
    .pass(pass), .fail(fail), .ep_addr(ep_addr), .ep_dout(ep_dout), .ep_doe_n(ep_doe_n), .ep_cs_n(ep_cs_n),
    .ep_oe_n(ep_oe_n), .ep_id_hv(ep_id_hv), .ep_vcc_prog(ep_vcc_prog), .ep_vpp_on(ep_vpp_on),
    .ep_width_word(ep_width_word), .start(start), .busy(busy));

// ---- bench/eps_seq_tb.sv ----
// self-checking bench for the eprom programming sequencer
`timescale 1ns/1ps
module eps_seq_tb;
    reg         mclk = 1'b0;
    reg         rst = 1'b1;
    reg         start = 1'b0;
    reg  [1:0]  cmd = 2'h0;
    reg  [7:0]  salt = 8'h00;
    integer     n_mismatch = 0;
    integer     check_count = 0;
    integer     cyc = 0;
    integer     i;
    wire        busy, done, pass, fail, doe_n, cs_n, oe_n, id_hv, vcc, vpp, wide;
    wire [15:0] rd_data, dout, din;
    wire [18:0] src_addr, addr;
    wire [15:0] src_data = {salt, src_addr[7:0]};
    // short timing keeps every run to a few thousand cycles
    eps_seq #(.PW_CYC(20), .SU_CYC(4), .VS_CYC(4)) i_eps_seq (.mclk(mclk), .rst(rst), .ce(1'b1), .start(start),
        .cmd(cmd), .last_addr(19'h00003), .busy(busy), .done(done), .pass(pass), .fail(fail), .rd_data(rd_data),
        .src_addr(src_addr), .src_data(src_data), .ep_addr(addr), .ep_dout(dout), .ep_doe_n(doe_n),
        .ep_din(din), .ep_cs_n(cs_n), .ep_oe_n(oe_n), .ep_id_hv(id_hv), .ep_vcc_prog(vcc), .ep_vpp_on(vpp),
        .ep_width_word(wide));
    eps_dev_model i_eps_dev_model (.mclk(mclk), .ep_addr(addr), .ep_dout(dout), .ep_cs_n(cs_n), .ep_oe_n(oe_n),
        .ep_id_hv(id_hv), .ep_vcc_prog(vcc), .ep_vpp_on(vpp), .ep_width_word(wide), .ep_din(din));
    // ----------------------------------------
    // clock, timeout and shared tasks
    // ----------------------------------------
    always #4 mclk = ~mclk;
    // a hang counts as a mismatch
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch = n_mismatch + 1;
            report_and_stop;
        end
    end
    task check(input [15:0] seen, input [15:0] exp, input [8*10-1:0] name);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %0s expected %h seen %h", name, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // cells 1 and 2 need n1 and n2 pulses, the rest one
    task prep(input [7:0] s, input [7:0] n1, input [7:0] n2);
        salt = s;
        for (i = 0; i < 8; i = i + 1) begin
            i_eps_dev_model.need[i] = (i == 1) ? n1 : (i == 2) ? n2 : 8'h01;
            i_eps_dev_model.cnt[i] = 8'h00;
        end
    endtask
    task kick(input [1:0] c);
        @(posedge mclk);
        start <= 1'b1;
        cmd <= c;
        @(posedge mclk);
        start <= 1'b0;
    endtask
    task wait_done;
        integer k;
        for (k = 0; k < 5000 && done !== 1'b1; k = k + 1) begin
            @(posedge mclk);
            #1;
        end
        check(done, 1'b1, "done");
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_prog_ok;
        prep(8'ha0, 8'h01, 8'h01);
        kick(2'h0);
        repeat (30) @(posedge mclk);
        kick(2'h1); // ignored while busy
        wait_done;
        check({pass, fail}, 2'b10, "ok verdict");
        for (i = 0; i < 4; i = i + 1) begin
            check(i_eps_dev_model.cnt[i], 8'h01, "one pulse");
            check(i_eps_dev_model.mem[i], {8'ha0, i[7:0]}, "cell data");
        end
        check(i_eps_dev_model.cnt[4], 8'h00, "past last");
    endtask
    task t_prog_retry;
        prep(8'hb0, 8'h01, 8'h04);
        kick(2'h0);
        wait_done;
        check({pass, fail}, 2'b10, "retry ok");
        check(i_eps_dev_model.cnt[2], 8'h04, "retry cnt");
        check(i_eps_dev_model.cnt[3], 8'h01, "next addr");
    endtask
    task t_prog_fail;
        // cell 2 would need a retry, so a missing abort shows in its count
        prep(8'hc0, 8'd99, 8'h02);
        kick(2'h0);
        wait_done;
        check({pass, fail}, 2'b01, "fail flag");
        check(i_eps_dev_model.cnt[1], 8'd11, "max pulses");
        check(i_eps_dev_model.cnt[2], 8'h01, "aborted");
        check({vpp, vcc}, 2'b00, "supplies");
    endtask
    task t_ident;
        for (i = 1; i < 4; i = i + 1) begin
            kick(i[1:0]);
            wait_done;
            check(rd_data, (i == 1) ? 16'h5a01 : (i == 2) ? 16'h5a02 : 16'hc000, "id word");
        end
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        check({cs_n, oe_n, doe_n, wide, vpp, vcc, id_hv, busy}, 8'hf0, "reset pins");
        t_prog_ok;
        t_prog_retry;
        t_prog_fail;
        t_ident;
        report_and_stop;
    end
endmodule

// ---- design/eps_map.vh ----
// constants for the eprom programming sequencer
`ifndef EPS_MAP_VH
`define EPS_MAP_VH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define EPS_CLK_MHZ        125
`define EPS_PW_NOM_NS      50000
`define EPS_PW_MIN_NS      47500
`define EPS_PW_MAX_NS      52500
`define EPS_SETUP_NS       2000
`define EPS_SUPPLY_NS      2000
`define EPS_PW_CYC         ((`EPS_PW_NOM_NS * `EPS_CLK_MHZ) / 1000)
`define EPS_SETUP_CYC      ((`EPS_SETUP_NS * `EPS_CLK_MHZ + 999) / 1000)
`define EPS_SUPPLY_CYC     ((`EPS_SUPPLY_NS * `EPS_CLK_MHZ + 999) / 1000)
`define EPS_FLOAT_CYC      17
// ----------------------------------------
// algorithm
// ----------------------------------------
`define EPS_MAX_RETRY      10
`define EPS_ADDR_W         19
`define EPS_ID_BIT         9
// ----------------------------------------
// commands
// ----------------------------------------
`define EPS_CMD_PROG       2'h0
`define EPS_CMD_ID_MFR     2'h1
`define EPS_CMD_ID_DEV     2'h2
`define EPS_CMD_READ       2'h3
`endif

// ---- design/eps_seq.v ----
// host-side programming and identification sequencer for a word eprom
`timescale 1ns/1ps
`include "eps_map.vh"
module eps_seq #(
    parameter AW     = `EPS_ADDR_W,
    parameter PW_CYC = `EPS_PW_CYC,
    parameter SU_CYC = `EPS_SETUP_CYC,
    parameter VS_CYC = `EPS_SUPPLY_CYC
) (
    // clock and reset
    input  wire          mclk,
    input  wire          rst,
    input  wire          ce,
    // command port
    input  wire          start,
    input  wire [1:0]    cmd,
    input  wire [AW-1:0] last_addr,
    output wire          busy,
    output reg           done,
    output reg           pass,
    output reg           fail,
    output reg  [15:0]   rd_data,
    // source data for the word being handled
    output reg  [AW-1:0] src_addr,
    input  wire [15:0]   src_data,
    // eprom pins
    output reg  [AW-1:0] ep_addr,
    output reg  [15:0]   ep_dout,
    output reg           ep_doe_n,
    input  wire [15:0]   ep_din,
    output reg           ep_cs_n,
    output reg           ep_oe_n,
    output reg           ep_id_hv,
    output reg           ep_vcc_prog,
    output reg           ep_vpp_on,
    output reg           ep_width_word
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam S_IDLE  = 4'h0;
    localparam S_VCC   = 4'h1;
    localparam S_VPP   = 4'h2;
    localparam S_SETUP = 4'h3;
    localparam S_PULSE = 4'h4;
    localparam S_HOLD  = 4'h5;
    localparam S_RDSU  = 4'h6;
    localparam S_RDWT  = 4'h7;
    localparam S_CMP   = 4'h8;
    localparam S_VOFF  = 4'h9;
    localparam S_COFF  = 4'ha;
    localparam S_DONE  = 4'hb;

    localparam P_FIRST = 2'h0;
    localparam P_VERI  = 2'h1;
    localparam P_FINAL = 2'h2;
    localparam P_READ  = 2'h3;

    reg [3:0]    state;
    reg [1:0]    phase;
    reg [3:0]    retry;
    reg          bad;
    reg [15:0]   s2;
    reg [15:0]   s3;
    reg [15:0]   s1;
    reg          tload;
    reg [15:0]   tcount;
    wire         tdone;
    wire         at_last = (src_addr == last_addr);
    wire         match   = (s3 == src_data) && (s2 == s3);

    // one timer serves all timed waits; loaded on every state change except into S_CMP, out of S_COFF and out of S_DONE
    eps_timer #(.W(16)) u_timer (
        .mclk  (mclk),
        .rst   (rst),
        .ce    (ce),
        .load  (tload),
        .count (tcount),
        .done  (tdone)
    );

    assign busy = (state != S_IDLE);

    // ----------------------------------------
    // pin input synchroniser
    // ----------------------------------------
    // three stages; a word counts once stages two and three agree
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1 <= 16'h0000;
            s2 <= 16'h0000;
            s3 <= 16'h0000;
        end else if (ce) begin
            s1 <= ep_din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= S_IDLE; phase <= P_FIRST; retry <= 4'h0; bad <= 1'b0;
            done <= 1'b0; pass <= 1'b0; fail <= 1'b0; rd_data <= 16'h0000;
            src_addr <= {AW{1'b0}}; ep_addr <= {AW{1'b0}}; ep_dout <= 16'h0000;
            ep_doe_n <= 1'b1; ep_cs_n <= 1'b1; ep_oe_n <= 1'b1; ep_id_hv <= 1'b0;
            ep_vcc_prog <= 1'b0; ep_vpp_on <= 1'b0; ep_width_word <= 1'b1;
            tload <= 1'b0; tcount <= 16'h0000;
        end else if (ce) begin
            tload <= 1'b0;
            done  <= 1'b0;
            case (state)
                S_IDLE: begin
                    ep_width_word <= 1'b1;                      // word organisation, never byte mode
                    if (start) begin
                        pass <= 1'b0; fail <= 1'b0; bad <= 1'b0; retry <= 4'h0;
                        src_addr <= {AW{1'b0}};
                        ep_addr  <= {AW{1'b0}};
                        tload <= 1'b1; tcount <= VS_CYC[15:0];
                        if (cmd == `EPS_CMD_PROG) begin
                            phase <= P_FIRST;
                            ep_vcc_prog <= 1'b1;
                            state <= S_VCC;
                        end else if (cmd == `EPS_CMD_READ) begin
                            phase <= P_READ;
                            state <= S_RDSU;
                        end else begin
                            // identity read: all lines low but bit zero
                            phase <= P_READ;
                            ep_id_hv <= 1'b1;
                            ep_addr <= {{(AW-1){1'b0}}, cmd == `EPS_CMD_ID_DEV};
                            state <= S_RDSU;
                        end
                    end
                end
                S_VCC: if (tdone) begin
                    ep_vpp_on <= 1'b1;
                    tload <= 1'b1; tcount <= VS_CYC[15:0];
                    state <= S_VPP;
                end
                S_VPP: if (tdone) begin                        // supplies settled
                    ep_dout <= src_data; ep_doe_n <= 1'b0; ep_oe_n <= 1'b1;
                    tload <= 1'b1; tcount <= SU_CYC[15:0];
                    state <= S_SETUP;
                end
                S_SETUP: if (tdone) begin
                    ep_cs_n <= 1'b0;
                    // timer load and zero detect add two cycles, so the pulse is exactly PW_CYC
                    tload <= 1'b1; tcount <= PW_CYC[15:0] - 16'd2;
                    state <= S_PULSE;
                end
                S_PULSE: if (tdone) begin
                    ep_cs_n <= 1'b1;
                    tload <= 1'b1; tcount <= SU_CYC[15:0];     // data hold
                    state <= S_HOLD;
                end
                S_HOLD: if (tdone) begin
                    ep_doe_n <= 1'b1;
                    if (phase == P_FIRST) begin
                        if (at_last) begin
                            phase <= P_VERI;
                            src_addr <= {AW{1'b0}}; ep_addr <= {AW{1'b0}};
                        end else begin
                            src_addr <= src_addr + 1'b1; ep_addr <= src_addr + 1'b1;
                        end
                        tload <= 1'b1; tcount <= SU_CYC[15:0];
                        state <= (at_last) ? S_RDSU : S_VPP;
                    end else begin
                        retry <= retry + 4'h1;
                        tload <= 1'b1; tcount <= SU_CYC[15:0];
                        state <= S_RDSU;
                    end
                end
                S_RDSU: if (tdone) begin
                    ep_oe_n <= 1'b0;
                    // plain and final verify reads need chip select; verify reads between pulses run with it high
                    if (phase == P_READ || phase == P_FINAL) ep_cs_n <= 1'b0;
                    tload <= 1'b1; tcount <= 16'd`EPS_FLOAT_CYC + 16'd3;
                    state <= S_RDWT;
                end
                S_RDWT: if (tdone) begin
                    state <= S_CMP;
                end
                S_CMP: if (s2 == s3) begin
                    ep_oe_n <= 1'b1; ep_cs_n <= 1'b1;
                    tload <= 1'b1; tcount <= SU_CYC[15:0];
                    if (phase == P_READ) begin
                        rd_data <= s3; ep_id_hv <= 1'b0;
                        pass <= 1'b1; state <= S_DONE;
                    end else if (match) begin
                        retry <= 4'h0;
                        if (at_last) begin
                            if (phase == P_VERI) begin
                                ep_vpp_on <= 1'b0;
                                tcount <= VS_CYC[15:0];
                                state <= S_VOFF;
                            end else begin
                                pass <= ~bad; fail <= bad;
                                state <= S_DONE;
                            end
                        end else begin
                            src_addr <= src_addr + 1'b1; ep_addr <= src_addr + 1'b1;
                            state <= S_RDSU;
                        end
                    end else if (phase == P_FINAL) begin
                        bad <= 1'b1;
                        if (at_last) begin
                            fail <= 1'b1; state <= S_DONE;
                        end else begin
                            src_addr <= src_addr + 1'b1; ep_addr <= src_addr + 1'b1;
                            state <= S_RDSU;
                        end
                    end else if (retry == 4'd`EPS_MAX_RETRY) begin
                        ep_vpp_on <= 1'b0; fail <= 1'b1;
                        tcount <= VS_CYC[15:0];
                        state <= S_COFF;
                    end else begin
                        ep_dout <= src_data; ep_doe_n <= 1'b0;
                        state <= S_SETUP;
                    end
                end
                S_VOFF: if (tdone) begin
                    ep_vcc_prog <= 1'b0;
                    phase <= P_FINAL;
                    src_addr <= {AW{1'b0}}; ep_addr <= {AW{1'b0}};
                    tload <= 1'b1; tcount <= VS_CYC[15:0];
                    state <= S_RDSU;
                end
                S_COFF: if (tdone) begin
                    ep_vcc_prog <= 1'b0;
                    state <= S_DONE;
                end
                S_DONE: begin
                    done  <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

// ---- design/eps_timer.v ----
// down counter that times phases of the sequence
`timescale 1ns/1ps
module eps_timer #(
    parameter W = 16
) (
    // clock and reset
    input  wire         mclk,
    input  wire         rst,
    input  wire         ce,
    // control
    input  wire         load,
    input  wire [W-1:0] count,
    // status
    output wire         done
);
    reg [W-1:0] cnt;

    // ----------------------------------------
    // counter
    // ----------------------------------------
    // counts to zero; load wins over counting
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt <= {W{1'b0}};
        end else if (ce) begin
            if (load) begin
                cnt <= count;
            end else if (cnt != {W{1'b0}}) begin
                cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign done = (cnt == {W{1'b0}}) & ~load;
endmodule
